// ### ppo_pkg.sv
`default_nettype none
package ppo_pkg;
    // port d pin indexes
    localparam int PD_TXD_BIT  = 3;
    localparam int PD_BITS     = 4;
    // port e pin indexes
    localparam int PE_RST_BIT  = 0;
    localparam int PE_XIN_BIT  = 1;
    localparam int PE_XOUT_BIT = 2;
    localparam int PE_BITS     = 3;
    // reset values of registered outputs
    localparam logic [3:0] PD_RESET_VAL = 4'h0;
    localparam logic [2:0] PE_RESET_VAL = 3'h0;
    // synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;
    // oscillator source selects
    typedef enum logic [1:0] {
        PPO_CLK_RC   = 2'h0,
        PPO_CLK_XTAL = 2'h1,
        PPO_CLK_EXT  = 2'h2,
        PPO_CLK_LFX  = 2'h3
    } ppo_clksrc_type;
endpackage : ppo_pkg
`default_nettype wire

// ### ppo_pin_cell.sv
`default_nettype none
// one pin: override muxing plus input synchroniser
module ppo_pin_cell
    import ppo_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic reg_pullup,
    input  wire logic reg_dir,
    input  wire logic reg_outval,
    input  wire logic pullup_override_enable,
    input  wire logic pullup_override_value,
    input  wire logic direction_override_enable,
    input  wire logic direction_override_value,
    input  wire logic outval_override_enable,
    input  wire logic outval_override_value,
    input  wire logic input_disable_override_enable,
    input  wire logic input_disable_override_value,
    input  wire logic pin_in,
    output logic      pull_d,
    output logic      dir_d,
    output logic      out_d,
    output logic      din_d
);
    logic [SYNC_STAGES-1:0] sync_q;
    logic                   in_dis;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync_q <= '0;
        end else begin
            sync_q <= {sync_q[SYNC_STAGES-2:0], pin_in};
        end
    end

    always_comb begin
        pull_d = pullup_override_enable    ? pullup_override_value    : reg_pullup;
        dir_d  = direction_override_enable ? direction_override_value : reg_dir;
        out_d  = outval_override_enable    ? outval_override_value    : reg_outval;
        in_dis = input_disable_override_enable & input_disable_override_value;
        // disabled input reads low to stop leakage current toggling logic
        din_d  = sync_q[SYNC_STAGES-1] & ~in_dis;
    end
endmodule : ppo_pin_cell
`default_nettype wire

// ### ppo_override.sv
`default_nettype none
module ppo_override
    import ppo_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  reset_n,
    input  wire logic [PD_BITS-1:0]    portd_outdata,
    input  wire logic [PD_BITS-1:0]    portd_direction,
    input  wire logic                  pullup_disable,
    input  wire logic [PD_BITS-1:0]    portd_pins,
    input  wire logic [PE_BITS-1:0]    porte_outdata,
    input  wire logic [PE_BITS-1:0]    porte_direction,
    input  wire logic [PE_BITS-1:0]    porte_pins,
    input  wire logic                  serial_transmit_enable,
    input  wire logic                  serial_txd,
    input  wire logic                  timer0_cmpa_out_enable,
    input  wire logic                  timer0_cmpa_out,
    input  wire logic                  timer0_cmpb_out_enable,
    input  wire logic                  timer0_cmpb_out,
    input  wire logic                  spi_enable_bit,
    input  wire logic                  spi_master_select,
    input  wire logic                  spi_alt_pin_select,
    input  wire logic                  spi_mosi,
    input  wire logic                  analog_ch0_input_disable,
    input  wire logic                  reset_pin_disable_fuse,
    input  wire ppo_clksrc_type        clock_source,
    output logic [PD_BITS-1:0]         portd_pad_out,
    output logic [PD_BITS-1:0]         portd_pad_oe,
    output logic [PD_BITS-1:0]         portd_pad_pullup,
    output logic [PD_BITS-1:0]         portd_pinread,
    output logic [PE_BITS-1:0]         porte_pad_out,
    output logic [PE_BITS-1:0]         porte_pad_oe,
    output logic [PE_BITS-1:0]         porte_pad_pullup,
    output logic [PE_BITS-1:0]         porte_pinread,
    output logic [PE_BITS-1:0]         porte_direction_read,
    output logic [PE_BITS-1:0]         porte_outdata_read,
    output logic [PE_BITS-1:0]         pin_change_src,
    output logic                       osc_pins_claimed,
    output logic                       reset_pin_active
);
    // ------------------------------------------------------------
    // override terms
    // ------------------------------------------------------------
    logic [PD_BITS-1:0] d_pullup_override_enable, d_pullup_override_value, d_direction_override_enable, d_direction_override_value, d_outval_override_enable, d_outval_override_value;
    logic [PE_BITS-1:0] e_outval_override_enable, e_outval_override_value, e_input_disable_override_enable, e_gpio_off;
    logic               spi_alt_master, spi_alt_slave, xin_used, xout_used, rst_pin;

    always_comb begin
        spi_alt_master = spi_enable_bit & spi_master_select & spi_alt_pin_select;
        spi_alt_slave  = spi_enable_bit & ~spi_master_select & spi_alt_pin_select;
        d_pullup_override_enable = '0;
        d_pullup_override_value = '0;
        d_direction_override_enable = '0;
        d_direction_override_value = '0;
        d_outval_override_enable = '0;
        d_outval_override_value = '0;
        d_pullup_override_enable[PD_TXD_BIT] = serial_transmit_enable | spi_alt_slave;
        d_pullup_override_value[PD_TXD_BIT] = ~serial_transmit_enable & spi_alt_slave
                             & portd_outdata[PD_TXD_BIT] & ~pullup_disable;
        d_direction_override_enable[PD_TXD_BIT] = serial_transmit_enable | spi_alt_slave;
        d_direction_override_value[PD_TXD_BIT] = serial_transmit_enable;
        d_outval_override_enable[PD_TXD_BIT] = serial_transmit_enable | timer0_cmpa_out_enable
                             | spi_alt_master;
        if (serial_transmit_enable) begin
            d_outval_override_value[PD_TXD_BIT] = serial_txd;
        end else if (timer0_cmpa_out_enable) begin
            d_outval_override_value[PD_TXD_BIT] = timer0_cmpa_out;
        end else begin
            d_outval_override_value[PD_TXD_BIT] = spi_alt_pin_select & spi_mosi;
        end
        // compare b covers both plain compare and pwm modes of timer0
        e_outval_override_enable = '0;
        e_outval_override_value = '0;
        e_outval_override_enable[PE_XIN_BIT] = timer0_cmpb_out_enable;
        e_outval_override_value[PE_XIN_BIT] = timer0_cmpb_out;
        e_input_disable_override_enable = '0;
        e_input_disable_override_enable[PE_XOUT_BIT] = analog_ch0_input_disable;
        xin_used  = (clock_source != PPO_CLK_RC);
        xout_used = (clock_source == PPO_CLK_XTAL) | (clock_source == PPO_CLK_LFX);
        rst_pin   = ~reset_pin_disable_fuse;
        e_gpio_off = '0;
        e_gpio_off[PE_XOUT_BIT] = xout_used;
        e_gpio_off[PE_XIN_BIT]  = xin_used;
        e_gpio_off[PE_RST_BIT]  = rst_pin;
    end

    // ------------------------------------------------------------
    // pin cells
    // ------------------------------------------------------------
    logic [PD_BITS-1:0] d_pull, d_dir, d_out, d_din;
    logic [PE_BITS-1:0] e_pull, e_dir, e_out, e_din;

    genvar gi;
    generate
        for (gi = 0; gi < PD_BITS; gi++) begin : g_pd
            ppo_pin_cell u_cell (
                .clk_sys                       (clk_sys),
                .reset_n                       (reset_n),
                .reg_pullup                    (portd_outdata[gi] & ~portd_direction[gi]
                                                & ~pullup_disable),
                .reg_dir                       (portd_direction[gi]),
                .reg_outval                    (portd_outdata[gi]),
                .pullup_override_enable        (d_pullup_override_enable[gi]),
                .pullup_override_value         (d_pullup_override_value[gi]),
                .direction_override_enable     (d_direction_override_enable[gi]),
                .direction_override_value      (d_direction_override_value[gi]),
                .outval_override_enable        (d_outval_override_enable[gi]),
                .outval_override_value         (d_outval_override_value[gi]),
                .input_disable_override_enable (1'b0),
                .input_disable_override_value  (1'b0),
                .pin_in                        (portd_pins[gi]),
                .pull_d                        (d_pull[gi]),
                .dir_d                         (d_dir[gi]),
                .out_d                         (d_out[gi]),
                .din_d                         (d_din[gi])
            );
        end
        for (gi = 0; gi < PE_BITS; gi++) begin : g_pe
            // direction is never overridden: software sets it for compare b
            ppo_pin_cell u_cell (
                .clk_sys                       (clk_sys),
                .reset_n                       (reset_n),
                .reg_pullup                    (porte_outdata[gi] & ~porte_direction[gi]
                                                & ~pullup_disable),
                .reg_dir                       (porte_direction[gi]),
                .reg_outval                    (porte_outdata[gi]),
                .pullup_override_enable        (1'b0),
                .pullup_override_value         (1'b0),
                .direction_override_enable     (1'b0),
                .direction_override_value      (1'b0),
                .outval_override_enable        (e_outval_override_enable[gi]),
                .outval_override_value         (e_outval_override_value[gi]),
                .input_disable_override_enable (e_input_disable_override_enable[gi]),
                .input_disable_override_value  (1'b1),
                .pin_in                        (porte_pins[gi]),
                .pull_d                        (e_pull[gi]),
                .dir_d                         (e_dir[gi]),
                .out_d                         (e_out[gi]),
                .din_d                         (e_din[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    logic [PD_BITS-1:0] pd_out_d, pd_oe_d, pd_pu_d, pd_rd_d;
    logic [PE_BITS-1:0] pe_out_d, pe_oe_d, pe_pu_d, pe_rd_d, pe_dir_rd_d, pe_dat_rd_d, pe_pc_d;

    always_comb begin
        pd_out_d    = d_out;
        pd_oe_d     = d_dir;
        pd_pu_d     = d_pull;
        pd_rd_d     = d_din;
        // claimed pins never drive and never pull up
        pe_out_d    = e_out & ~e_gpio_off;
        pe_oe_d     = e_dir & ~e_gpio_off;
        pe_pu_d     = e_pull & ~e_gpio_off;
        pe_rd_d     = e_din & ~e_gpio_off;
        pe_dir_rd_d = porte_direction;
        pe_dat_rd_d = porte_outdata;
        pe_dir_rd_d[PE_RST_BIT] = porte_direction[PE_RST_BIT] & ~rst_pin;
        pe_dat_rd_d[PE_RST_BIT] = porte_outdata[PE_RST_BIT] & ~rst_pin;
        pe_pc_d     = e_din;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            portd_pad_out        <= PD_RESET_VAL;
            portd_pad_oe         <= PD_RESET_VAL;
            portd_pad_pullup     <= PD_RESET_VAL;
            portd_pinread        <= PD_RESET_VAL;
            porte_pad_out        <= PE_RESET_VAL;
            porte_pad_oe         <= PE_RESET_VAL;
            porte_pad_pullup     <= PE_RESET_VAL;
            porte_pinread        <= PE_RESET_VAL;
            porte_direction_read <= PE_RESET_VAL;
            porte_outdata_read   <= PE_RESET_VAL;
            pin_change_src       <= PE_RESET_VAL;
            osc_pins_claimed     <= 1'b0;
            reset_pin_active     <= 1'b0;
        end else begin
            portd_pad_out        <= pd_out_d;
            portd_pad_oe         <= pd_oe_d;
            portd_pad_pullup     <= pd_pu_d;
            portd_pinread        <= pd_rd_d;
            porte_pad_out        <= pe_out_d;
            porte_pad_oe         <= pe_oe_d;
            porte_pad_pullup     <= pe_pu_d;
            porte_pinread        <= pe_rd_d;
            porte_direction_read <= pe_dir_rd_d;
            porte_outdata_read   <= pe_dat_rd_d;
            pin_change_src       <= pe_pc_d;
            osc_pins_claimed     <= xin_used;
            reset_pin_active     <= rst_pin;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_serial_transmit_enable;
        serial_transmit_enable && $stable(serial_txd);
    endsequence

    a_txd_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_serial_transmit_enable |=> portd_pad_out[PD_TXD_BIT] == $past(serial_txd))
        else $error("pd3 does not carry transmit data");
    a_cmpa_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !serial_transmit_enable && timer0_cmpa_out_enable
        |=> portd_pad_out[PD_TXD_BIT] == $past(timer0_cmpa_out))
        else $error("pd3 does not carry compare a");
    a_pd3_plain: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !serial_transmit_enable && !timer0_cmpa_out_enable && !spi_alt_master
        |=> portd_pad_out[PD_TXD_BIT] == $past(portd_outdata[PD_TXD_BIT]))
        else $error("pd3 overridden without cause");
    a_cmpb_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
        timer0_cmpb_out_enable && !xin_used
        |=> porte_pad_out[PE_XIN_BIT] == $past(timer0_cmpb_out))
        else $error("pe1 does not carry compare b");
    a_cmpb_dir: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !xin_used |=> porte_pad_oe[PE_XIN_BIT] == $past(porte_direction[PE_XIN_BIT]))
        else $error("pe1 direction overridden");
    a_rst_reads: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !reset_pin_disable_fuse |=> porte_direction_read[PE_RST_BIT] == 1'b0
        && porte_outdata_read[PE_RST_BIT] == 1'b0 && porte_pinread[PE_RST_BIT] == 1'b0)
        else $error("reset pin bits read nonzero");
    a_rst_no_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !reset_pin_disable_fuse |=> !porte_pad_oe[PE_RST_BIT])
        else $error("reset pin driven as gpio");
    a_rst_gpio: assert property (@(posedge clk_sys) disable iff (!reset_n)
        reset_pin_disable_fuse |=> porte_outdata_read[PE_RST_BIT]
        == $past(porte_outdata[PE_RST_BIT]))
        else $error("pe0 not ordinary gpio");
    a_xout_claim: assert property (@(posedge clk_sys) disable iff (!reset_n)
        xout_used |=> !porte_pad_oe[PE_XOUT_BIT])
        else $error("pe2 driven while oscillator output");
    a_xin_claim: assert property (@(posedge clk_sys) disable iff (!reset_n)
        xin_used |=> !porte_pad_oe[PE_XIN_BIT] && osc_pins_claimed)
        else $error("pe1 driven while oscillator input");
    a_adc0_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
        analog_ch0_input_disable[*3] |=> pin_change_src[PE_XOUT_BIT] == 1'b0)
        else $error("pe2 input not disabled");
    // two synchroniser flops plus the output flop: a pin level shows three edges later
    a_pc_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $past(reset_n, 3) |-> pin_change_src
        == ($past(porte_pins, 3) & {~$past(analog_ch0_input_disable), 2'b11}))
        else $error("pin change source mismatch");
endmodule : ppo_override
`default_nettype wire

// ### ppo_board.sv
`default_nettype none
// ----------------------------------------
// board side of the port pins
// ----------------------------------------
module ppo_board #(
    parameter int W = 4
) (
    input  wire logic         clk_sys,
    input  wire logic [W-1:0] pad_out,
    input  wire logic [W-1:0] pad_oe,
    input  wire logic [W-1:0] pad_pullup,
    input  wire logic [W-1:0] ext_en,
    input  wire logic [W-1:0] ext_val,
    output logic      [W-1:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // undriven pins wander so a stale level never reads as valid
    logic [W-1:0] float_q = '0;
    always @(posedge clk_sys) float_q <= ~float_q;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (pad_oe[i]) pins[i] = pad_out[i];
            else if (ext_en[i]) pins[i] = ext_val[i];
            else if (pad_pullup[i]) pins[i] = 1'b1;
            else pins[i] = float_q[i];
        end
    end
endmodule : ppo_board
`default_nettype wire

// ### tb.sv
`default_nettype none
// ----------------------------------------
// pin override bench
// ----------------------------------------
module tb
    import ppo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, reset_n, pullup_disable, serial_transmit_enable, serial_txd;
    logic timer0_cmpa_out_enable, timer0_cmpa_out, timer0_cmpb_out_enable, timer0_cmpb_out;
    logic spi_enable_bit, spi_master_select, spi_alt_pin_select, spi_mosi;
    logic analog_ch0_input_disable, reset_pin_disable_fuse;
    logic [3:0] portd_outdata, portd_direction, pd_ext;
    logic [2:0] porte_outdata, porte_direction, pe_ext;
    ppo_clksrc_type clock_source;
    wire logic [3:0] portd_pins, pd_out, pd_oe, pd_pu, portd_pinread;
    wire logic [2:0] porte_pins, pe_out, pe_oe, pe_pu, porte_pinread, pe_dir_rd, pe_out_rd, pcs;
    wire logic osc_claim, rst_act;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    logic en, val;

    ppo_override uut (.clk_sys(clk_sys), .reset_n(reset_n), .portd_outdata(portd_outdata),
        .portd_direction(portd_direction), .pullup_disable(pullup_disable),
        .portd_pins(portd_pins), .porte_outdata(porte_outdata),
        .porte_direction(porte_direction), .porte_pins(porte_pins),
        .serial_transmit_enable(serial_transmit_enable), .serial_txd(serial_txd),
        .timer0_cmpa_out_enable(timer0_cmpa_out_enable), .timer0_cmpa_out(timer0_cmpa_out),
        .timer0_cmpb_out_enable(timer0_cmpb_out_enable), .timer0_cmpb_out(timer0_cmpb_out),
        .spi_enable_bit(spi_enable_bit), .spi_master_select(spi_master_select),
        .spi_alt_pin_select(spi_alt_pin_select), .spi_mosi(spi_mosi),
        .analog_ch0_input_disable(analog_ch0_input_disable),
        .reset_pin_disable_fuse(reset_pin_disable_fuse), .clock_source(clock_source),
        .portd_pad_out(pd_out), .portd_pad_oe(pd_oe), .portd_pad_pullup(pd_pu),
        .portd_pinread(portd_pinread), .porte_pad_out(pe_out), .porte_pad_oe(pe_oe),
        .porte_pad_pullup(pe_pu), .porte_pinread(porte_pinread),
        .porte_direction_read(pe_dir_rd), .porte_outdata_read(pe_out_rd),
        .pin_change_src(pcs), .osc_pins_claimed(osc_claim), .reset_pin_active(rst_act));
    ppo_board #(.W(4)) board_d (.clk_sys(clk_sys), .pad_out(pd_out), .pad_oe(pd_oe),
        .pad_pullup(pd_pu), .ext_en(4'hf), .ext_val(pd_ext), .pins(portd_pins));
    ppo_board #(.W(3)) board_e (.clk_sys(clk_sys), .pad_out(pe_out), .pad_oe(pe_oe),
        .pad_pullup(pe_pu), .ext_en(3'h7), .ext_val(pe_ext), .pins(porte_pins));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // inputs move 2 ns after the edge, checks happen at that same offset
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask : step

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            wrap_up();
        end
    end

    initial begin
        reset_n = 1'b0;
        {pullup_disable, serial_transmit_enable, serial_txd, timer0_cmpa_out_enable} = '0;
        {timer0_cmpa_out, timer0_cmpb_out_enable, timer0_cmpb_out, spi_enable_bit} = '0;
        {spi_master_select, spi_alt_pin_select, spi_mosi, analog_ch0_input_disable} = '0;
        reset_pin_disable_fuse = 1'b1;
        clock_source = PPO_CLK_RC;
        portd_outdata = 4'ha;
        portd_direction = 4'h5;
        pd_ext = 4'h0;
        porte_outdata = 3'h0;
        porte_direction = 3'h0;
        pe_ext = 3'h0;
        step(10);
        check("rst_oe", {1'b0, pe_oe, pd_oe}, 8'h00);
        reset_n = 1'b1;
        step(1);
        check("pd_out", pd_out, 8'h0a);
        check("pd_oe", pd_oe, 8'h05);
        // ---------------- pd3 priority over all 512 combinations
        portd_direction = 4'h8;
        for (int i = 0; i < 512; i++) begin
            {portd_outdata[3], serial_transmit_enable, serial_txd, timer0_cmpa_out_enable,
             timer0_cmpa_out, spi_enable_bit, spi_master_select, spi_alt_pin_select,
             spi_mosi} = 9'(i);
            step(1);
            en = serial_transmit_enable | timer0_cmpa_out_enable
                 | (spi_enable_bit & spi_master_select & spi_alt_pin_select);
            val = serial_transmit_enable ? serial_txd : timer0_cmpa_out_enable
                  ? timer0_cmpa_out : (spi_alt_pin_select & spi_mosi);
            check("pd3_out", pd_out[3], en ? val : portd_outdata[3]);
        end
        // alternate spi slave takes pd3 pull-up and direction away from the registers
        {serial_transmit_enable, timer0_cmpa_out_enable, spi_master_select} = '0;
        step(1);
        check("pd3_pu_oe", {pd_pu[3], pd_oe[3]}, 8'h02);
        spi_enable_bit = 1'b0;
        // ---------------- pe1 compare b / pwm output
        porte_direction = 3'h2;
        timer0_cmpb_out_enable = 1'b1;
        for (int v = 0; v < 2; v++) begin
            timer0_cmpb_out = v[0];
            step(1);
            check("pe1_out", pe_out[1], v[0]);
            check("pe1_oe", pe_oe[1], 1'b1);
        end
        timer0_cmpb_out_enable = 1'b0;
        porte_outdata = 3'h2;
        step(1);
        check("pe1_gpio", pe_out[1], 1'b1);
        timer0_cmpb_out_enable = 1'b1;
        porte_direction = 3'h0;
        step(1);
        check("pe1_dir", pe_oe[1], 1'b0);
        timer0_cmpb_out_enable = 1'b0;
        // ---------------- oscillator claims per clock source
        porte_direction = 3'h7;
        porte_outdata = 3'h7;
        pe_ext = 3'h7;
        for (int c = 0; c < 4; c++) begin
            clock_source = ppo_clksrc_type'(c[1:0]);
            step(3);
            en = (c != 0);
            val = (c == 1 || c == 3);
            check("osc_claim", osc_claim, en);
            check("pe_oe", pe_oe, {~val, ~en, 1'b1});
            check("pe_pinread", porte_pinread, {~val, ~en, 1'b1});
        end
        clock_source = PPO_CLK_RC;
        // ---------------- pe0 reset pin against gpio
        porte_direction = 3'h1;
        porte_outdata = 3'h1;
        reset_pin_disable_fuse = 1'b0;
        step(3);
        check("rst_act", rst_act, 1'b1);
        check("pe0_oe", pe_oe[0], 1'b0);
        check("pe0_reads", {pe_dir_rd[0], pe_out_rd[0], porte_pinread[0]}, 8'h0);
        reset_pin_disable_fuse = 1'b1;
        step(3);
        check("rst_off", {rst_act, pe_oe[0], pe_out[0]}, 8'h3);
        check("pe0_rd", {pe_dir_rd[0], pe_out_rd[0], porte_pinread[0]}, 8'h7);
        // ---------------- digital inputs and pin change sources
        porte_direction = 3'h0;
        portd_direction = 4'h0;
        pd_ext = 4'h6;
        for (int k = 0; k < 3; k++) begin
            analog_ch0_input_disable = (k == 2);
            pe_ext = (k == 0) ? 3'h5 : (k == 1) ? 3'h2 : 3'h7;
            step(3);
            check("pe_in", porte_pinread, (k == 2) ? 3'h3 : pe_ext);
            check("pcs", pcs, (k == 2) ? 3'h3 : pe_ext);
        end
        check("pd_in", portd_pinread, 8'h06);
        check("pullups", {1'b0, pe_pu, pd_pu}, 8'h1a);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
